/* common/msc_pkg.sv */
// Behaviour
// - six modes: init, normal, stop, sleep, restart, failsafe
// - init at power-up and after soft reset
// - stop keeps regulator on, sleep turns off
// - restart with reset after wake or failure
// - critical failures such as overtemperature go failsafe
// - debug mode still reaches every operating mode
// - debug mode: watchdog runs, no reset issued
// - debug mode: watchdog failure pulls interrupt low
// - host may re-enable watchdog resets in debug
// - watchdog always starts with long open window
// - host configures over 32-bit serial frames
// - straps give debug select and checksum enable
// - straps at power-up init; checksum also restart
// - weak pull-up on interrupt pin after release
// - debug select only in power-up init, supplies good
// - pulled-down pin plus any command latches debug
// - pulled-up or floating pin keeps normal operation
// - pin judged only through fixed-time filter
// - filtered pin level starts at one on release
// - autonomous mode change while monitoring cancels debug
// - pulled-down checksum strap enables, open disables
// - checksum strap filtered during delay, latched on release
// - two fixed frames set or clear checksum in normal
package msc_pkg;

   // timing, figures in their own unit and derived cycle counts
   localparam int CLK_PERIOD_NS        = 20;
   localparam int STRAP_FILTER_TIME_NS = 1000;
   localparam int RESET_DELAY_TIME_NS  = 10000;
   localparam int INT_PULSE_TIME_NS    = 2000;
   localparam int STRAP_FILTER_CYC     = (STRAP_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_DELAY_CYC      = (RESET_DELAY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INT_PULSE_CYC        = INT_PULSE_TIME_NS / CLK_PERIOD_NS;
   localparam int CNT_W                = 10;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;

   // control fields
   localparam int CTRL_MODE_LSB   = 0;
   localparam int CTRL_MODE_REQ   = 3;
   localparam int CTRL_SOFT_RST   = 4;
   localparam int CTRL_WD_RST_EN  = 5;

   // status fields
   localparam int ST_MODE_LSB     = 0;
   localparam int ST_DEBUG        = 3;
   localparam int ST_CHECKSUM     = 4;
   localparam int ST_RST_HIGH     = 5;
   localparam int ST_WD_RST_EN    = 6;
   localparam int ST_INTN_FILT    = 7;
   localparam int ST_INIT_POR     = 8;

   // reset values
   localparam logic DEBUG_RST     = 1'b0;
   localparam logic CHECKSUM_RST  = 1'b0;
   localparam logic WD_RST_EN_RST = 1'b0;
   localparam logic STRAP_IDLE    = 1'b1;

   // checksum recovery frames
   localparam logic [31:0] CHECKSUM_ON_FRAME  = 32'h67aaaa0e;
   localparam logic [31:0] CHECKSUM_OFF_FRAME = 32'he7aaaac3;

   typedef enum logic [2:0] {
      MSC_INIT,
      MSC_NORMAL,
      MSC_STOP,
      MSC_SLEEP,
      MSC_RESTART,
      MSC_FAILSAFE
   } msc_mode_t;

   // device events from supervision blocks
   typedef struct packed {
      logic thermal;
      logic undervolt;
      logic wd_fail;
      logic wake;
   } msc_event_t;

   // serial interface command strobes
   typedef struct packed {
      logic        cmd;
      logic        frame_valid;
      logic [31:0] frame;
   } msc_spi_t;

   typedef struct packed {
      msc_mode_t        mode;
      logic             init_por;
      logic [CNT_W-1:0] rst_cnt;
      logic             rst_high;
      logic             wd_start;
      logic [CNT_W-1:0] filt_cnt;
      logic             intn_filt;
      logic [CNT_W-1:0] ck_cnt;
      logic             ck_filt;
      logic             debug;
      logic             checksum;
      logic             wd_reset_en;
      logic [CNT_W-1:0] int_cnt;
      logic             intn_oe;
      logic             reg_on;
      logic             dp_wr;
      logic [7:0]       dp_addr;
      logic [31:0]      rdata;
      logic             ready;
   } msc_state_t;

endpackage

/* logic/msc_top.sv */
`timescale 1ns/1ps
module msc_top (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic              por_ok,
   input  wire logic              supply_ok,
   input  wire msc_pkg::msc_event_t events,
   input  wire msc_pkg::msc_spi_t   spi,
   input  wire logic              intn_in,
   output logic                   intn_out,
   output logic                   intn_oe,
   output logic                   intn_pullup_en,
   input  wire logic              pwm_checksum_strap_pin,
   output logic                   reset_out_low,
   output logic                   main_regulator_en,
   output logic                   wd_long_window,
   output logic                   wd_running,
   output logic                   checksum_en,
   output logic                   debug_mode
);

   msc_pkg::msc_state_t st;
   msc_pkg::msc_state_t next_st;

   // assertion clock and reset for the whole module
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   localparam logic [msc_pkg::CNT_W-1:0] FILT_LAST  = msc_pkg::CNT_W'(msc_pkg::STRAP_FILTER_CYC - 1);
   localparam logic [msc_pkg::CNT_W-1:0] DELAY_LAST = msc_pkg::CNT_W'(msc_pkg::RESET_DELAY_CYC - 1);
   localparam logic [msc_pkg::CNT_W-1:0] PULSE_LAST = msc_pkg::CNT_W'(msc_pkg::INT_PULSE_CYC - 1);

   // refuse counts that the shared counter width cannot hold
   if (msc_pkg::RESET_DELAY_CYC > (1 << msc_pkg::CNT_W) || msc_pkg::RESET_DELAY_CYC < 1 ||
       msc_pkg::INT_PULSE_CYC > (1 << msc_pkg::CNT_W) || msc_pkg::INT_PULSE_CYC < 1 ||
       msc_pkg::STRAP_FILTER_CYC > (1 << msc_pkg::CNT_W) || msc_pkg::STRAP_FILTER_CYC < 1) begin : g_cnt_check
      $error("counter width too small for the timing counts");
   end

   // combinational helpers
   logic             addr_ph;
   logic             wr_ctrl;
   logic             mode_req;
   logic             soft_rst;
   logic             wd_ok_mode;
   logic             wd_rst;
   logic             wd_int;
   logic             monitor;
   logic             auto_chg;
   logic             leave_rst;
   msc_pkg::msc_mode_t req_mode;
   logic [31:0]      status_word;
   logic [31:0]      ctrl_word;

   // next state of the whole block
   always_comb begin
      next_st          = st;
      next_st.wd_start = 1'b0;
      next_st.ready    = 1'b1;
      auto_chg         = 1'b0;
      leave_rst        = 1'b0;

      // bus address phase, one word per register, zero wait states
      addr_ph     = hsel && htrans[1] && hready;
      status_word = '0;
      status_word[msc_pkg::ST_MODE_LSB +: 3] = st.mode;
      status_word[msc_pkg::ST_DEBUG]         = st.debug;
      status_word[msc_pkg::ST_CHECKSUM]      = st.checksum;
      status_word[msc_pkg::ST_RST_HIGH]      = st.rst_high;
      status_word[msc_pkg::ST_WD_RST_EN]     = st.wd_reset_en;
      status_word[msc_pkg::ST_INTN_FILT]     = st.intn_filt;
      status_word[msc_pkg::ST_INIT_POR]      = st.init_por;
      ctrl_word = '0;
      ctrl_word[msc_pkg::CTRL_WD_RST_EN]     = st.wd_reset_en;
      next_st.dp_wr   = addr_ph && hwrite;
      next_st.dp_addr = haddr[7:0];
      next_st.rdata   = '0;
      if (addr_ph && !hwrite) begin
         case (haddr[7:0])
            msc_pkg::CTRL_OFS:   next_st.rdata = ctrl_word;
            msc_pkg::STATUS_OFS: next_st.rdata = status_word;
            default:             next_st.rdata = '0;
         endcase
      end

      // write data phase decode
      wr_ctrl  = st.dp_wr && (st.dp_addr == msc_pkg::CTRL_OFS);
      mode_req = wr_ctrl && hwdata[msc_pkg::CTRL_MODE_REQ];
      soft_rst = wr_ctrl && hwdata[msc_pkg::CTRL_SOFT_RST];
      req_mode = msc_pkg::msc_mode_t'(hwdata[msc_pkg::CTRL_MODE_LSB +: 3]);
      if (wr_ctrl) begin
         next_st.wd_reset_en = hwdata[msc_pkg::CTRL_WD_RST_EN];
      end

      // watchdog failure routing
      wd_ok_mode = st.rst_high && (st.mode == msc_pkg::MSC_INIT || st.mode == msc_pkg::MSC_NORMAL ||
                                   st.mode == msc_pkg::MSC_STOP);
      wd_rst = events.wd_fail && wd_ok_mode && (!st.debug || st.wd_reset_en);
      wd_int = events.wd_fail && wd_ok_mode && st.debug && !st.wd_reset_en;

      monitor = (st.mode == msc_pkg::MSC_INIT) && st.init_por && st.rst_high && supply_ok && por_ok;

      if (events.thermal && st.mode != msc_pkg::MSC_FAILSAFE) begin
         next_st.mode     = msc_pkg::MSC_FAILSAFE;
         next_st.rst_high = 1'b0;
         auto_chg         = 1'b1;
      end else if (wd_rst || (events.undervolt && wd_ok_mode)) begin
         next_st.mode     = msc_pkg::MSC_RESTART;
         next_st.rst_high = 1'b0;
         next_st.rst_cnt  = '0;
         auto_chg         = 1'b1;
      end else if (events.wake && (st.mode == msc_pkg::MSC_SLEEP ||
                                   st.mode == msc_pkg::MSC_FAILSAFE)) begin
         next_st.mode     = msc_pkg::MSC_RESTART;
         next_st.rst_high = 1'b0;
         next_st.rst_cnt  = '0;
         auto_chg         = 1'b1;
      end else if (soft_rst) begin
         next_st.mode     = msc_pkg::MSC_INIT;
         next_st.init_por = 1'b0;
         next_st.rst_high = 1'b0;
         next_st.rst_cnt  = '0;
      // host mode requests, debug or not
      end else if (mode_req) begin
         case (st.mode)
            msc_pkg::MSC_INIT: begin
               if (req_mode == msc_pkg::MSC_NORMAL && st.rst_high) begin
                  next_st.mode = msc_pkg::MSC_NORMAL;
               end
            end
            msc_pkg::MSC_NORMAL: begin
               if (req_mode == msc_pkg::MSC_STOP || req_mode == msc_pkg::MSC_NORMAL) begin
                  next_st.mode = req_mode;
               end else if (req_mode == msc_pkg::MSC_SLEEP) begin
                  next_st.mode     = msc_pkg::MSC_SLEEP;
                  next_st.rst_high = 1'b0;
               end
            end
            msc_pkg::MSC_STOP: begin
               if (req_mode == msc_pkg::MSC_NORMAL) begin
                  next_st.mode = msc_pkg::MSC_NORMAL;
               end
            end
            default: begin
               next_st.mode = st.mode;
            end
         endcase
      end

      // reset delay count, release of reset output
      if (!st.rst_high && (st.mode == msc_pkg::MSC_INIT || st.mode == msc_pkg::MSC_RESTART) &&
          next_st.mode == st.mode && supply_ok && por_ok) begin
         if (st.rst_cnt == DELAY_LAST) begin
            leave_rst        = 1'b1;
            next_st.rst_high = 1'b1;
            next_st.rst_cnt  = '0;
         end else begin
            next_st.rst_cnt = st.rst_cnt + 1'b1;
         end
      end

      if (!st.rst_high && (st.mode == msc_pkg::MSC_INIT || st.mode == msc_pkg::MSC_RESTART)) begin
         if (pwm_checksum_strap_pin != st.ck_filt) begin
            if (st.ck_cnt == FILT_LAST) begin
               next_st.ck_filt = pwm_checksum_strap_pin;
               next_st.ck_cnt  = '0;
            end else begin
               next_st.ck_cnt = st.ck_cnt + 1'b1;
            end
         end else begin
            next_st.ck_cnt = '0;
         end
      end

      if (st.rst_high) begin
         if (intn_in != st.intn_filt) begin
            if (st.filt_cnt == FILT_LAST) begin
               next_st.intn_filt = intn_in;
               next_st.filt_cnt  = '0;
            end else begin
               next_st.filt_cnt = st.filt_cnt + 1'b1;
            end
         end else begin
            next_st.filt_cnt = '0;
         end
      end

      if (leave_rst) begin
         next_st.wd_start  = 1'b1;
         next_st.intn_filt = 1'b1;
         next_st.filt_cnt  = '0;
         // checksum sampled in power-up init or restart
         if (st.init_por || st.mode == msc_pkg::MSC_RESTART) begin
            next_st.checksum = !st.ck_filt;
         end
         if (st.mode == msc_pkg::MSC_RESTART) begin
            next_st.mode = msc_pkg::MSC_NORMAL;
         end
      end

      if (monitor && spi.cmd) begin
         next_st.debug = !st.intn_filt;
      end
      if (monitor && auto_chg) begin
         next_st.debug = 1'b0;
      end
      // the power-up window closes once init is left
      if (next_st.mode != msc_pkg::MSC_INIT) begin
         next_st.init_por = 1'b0;
      end

      // checksum recovery frames in normal mode
      if (spi.frame_valid && st.mode == msc_pkg::MSC_NORMAL) begin
         if (spi.frame == msc_pkg::CHECKSUM_ON_FRAME) begin
            next_st.checksum = 1'b1;
         end else if (spi.frame == msc_pkg::CHECKSUM_OFF_FRAME) begin
            next_st.checksum = 1'b0;
         end
      end

      // watchdog failure stretched on interrupt pin
      if (wd_int) begin
         next_st.intn_oe = 1'b1;
         next_st.int_cnt = PULSE_LAST;
      end else if (st.int_cnt != '0) begin
         next_st.int_cnt = st.int_cnt - 1'b1;
      end else begin
         next_st.intn_oe = 1'b0;
      end
      if (!next_st.rst_high) begin
         next_st.intn_oe = 1'b0;
         next_st.int_cnt = '0;
      end

      next_st.reg_on = (next_st.mode != msc_pkg::MSC_SLEEP);
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st             <= '0;
         st.mode        <= msc_pkg::MSC_INIT;
         st.init_por    <= 1'b1;
         st.intn_filt   <= 1'b1;
         st.ck_filt     <= msc_pkg::STRAP_IDLE;
         st.debug       <= msc_pkg::DEBUG_RST;
         st.checksum    <= msc_pkg::CHECKSUM_RST;
         st.wd_reset_en <= msc_pkg::WD_RST_EN_RST;
         st.reg_on      <= 1'b1;
         st.ready       <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register, hresp and intn_out tied low
   assign hrdata            = st.rdata;
   assign hreadyout         = st.ready;
   assign hresp             = 1'b0;
   assign intn_out          = 1'b0;
   assign intn_oe           = st.intn_oe;
   assign intn_pullup_en    = st.rst_high;
   assign reset_out_low     = st.rst_high;
   assign main_regulator_en = st.reg_on;
   assign wd_long_window    = st.wd_start;
   assign wd_running        = st.rst_high;
   assign checksum_en       = st.checksum;
   assign debug_mode        = st.debug;

   // assertions
   sequence s_mon_cmd_low;
      monitor && spi.cmd && !st.intn_filt && !auto_chg;
   endsequence

   sequence s_debug_wd_fail;
      wd_int ##1 intn_oe;
   endsequence

   a_failsafe_on_heat:
   assert property (events.thermal && st.mode != msc_pkg::MSC_FAILSAFE
                    |=> st.mode == msc_pkg::MSC_FAILSAFE && !reset_out_low)
      else $error("thermal failure did not reach failsafe");

   a_restart_on_wake:
   assert property (events.wake && !events.thermal && st.mode == msc_pkg::MSC_SLEEP
                    |=> st.mode == msc_pkg::MSC_RESTART && !reset_out_low)
      else $error("wake from sleep did not restart");

   a_debug_no_reset:
   assert property (s_debug_wd_fail |-> st.mode != msc_pkg::MSC_RESTART && reset_out_low)
      else $error("watchdog reset issued in debug mode");

   a_debug_intn_pulse:
   assert property (wd_int && !events.thermal && !events.undervolt && !soft_rst && !mode_req
                    |=> intn_oe [*8])
      else $error("interrupt pin not driven on watchdog failure");

   a_wd_reset_on:
   assert property (events.wd_fail && wd_ok_mode && st.wd_reset_en && !events.thermal
                    |=> st.mode == msc_pkg::MSC_RESTART)
      else $error("re-enabled watchdog reset not applied");

   a_long_window:
   assert property ($rose(reset_out_low) |-> wd_long_window && st.intn_filt)
      else $error("watchdog start without long window");

   a_sleep_reg_off:
   assert property (st.mode == msc_pkg::MSC_SLEEP |-> !main_regulator_en)
      else $error("regulator on in sleep");

   a_stop_reg_on:
   assert property (st.mode == msc_pkg::MSC_STOP |-> main_regulator_en)
      else $error("regulator off in stop");

   a_debug_latch:
   assert property (s_mon_cmd_low |=> debug_mode)
      else $error("debug select not latched");

   a_debug_cancel:
   assert property (monitor && auto_chg |=> !debug_mode)
      else $error("debug kept after autonomous change");

   a_pullup_release:
   assert property (reset_out_low |-> intn_pullup_en)
      else $error("pull-up missing after release");

   a_checksum_frame:
   assert property (spi.frame_valid && st.mode == msc_pkg::MSC_NORMAL &&
                    spi.frame == msc_pkg::CHECKSUM_OFF_FRAME && !leave_rst |=> !checksum_en)
      else $error("checksum off frame ignored");

   a_checksum_hold:
   assert property (st.mode == msc_pkg::MSC_NORMAL && !spi.frame_valid |=> $stable(checksum_en))
      else $error("checksum changed in normal mode");

endmodule

/* tb/msc_host_model.sv */
`timescale 1ns/1ps
// host side: serial commands and the external strap on the interrupt/test pin
module msc_host_model (
   input  wire logic         hclk,
   input  wire logic         pull_down,
   input  wire logic         intn_oe,
   input  wire logic         intn_out,
   input  wire logic         intn_pullup_en,
   output msc_pkg::msc_spi_t spi,
   output wire logic         intn_in
);
   logic toggle = 1'b0;

   // idle serial strobes at time zero
   initial begin
      spi = '0;
   end

   // pattern for an undriven pin, so no stale level survives
   always @(posedge hclk) begin
      toggle <= ~toggle;
   end

   assign intn_in = intn_oe ? intn_out : (pull_down ? 1'b0 : (intn_pullup_en ? 1'b1 : toggle));

   task automatic command(input logic [31:0] frame, input logic valid);
      @(posedge hclk);
      spi <= '{cmd: 1'b1, frame_valid: valid, frame: frame};
      @(posedge hclk);
      spi <= '{cmd: 1'b0, frame_valid: 1'b0, frame: ~frame};
   endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [31:0] v;
      logic [31:0] m;
   } msc_tb_note_t;
   logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp, por_ok, supply_ok;
   logic                intn_in, intn_out, intn_oe, intn_pullup_en, strap, reset_out_low;
   logic                main_regulator_en, wd_long_window, wd_running, checksum_en, debug_mode;
   logic                pull_down, rd_dp, prev_rst;
   logic [1:0]          htrans;
   logic [2:0]          hsize;
   logic [31:0]         haddr, hwdata, hrdata;
   logic [31:0]         fr [3];
   logic                ex [3];
   msc_pkg::msc_event_t events;
   msc_pkg::msc_spi_t   spi;
   msc_tb_note_t        notes [$];
   msc_tb_note_t        n;
   int                  num_errors, check_count;

   msc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .por_ok(por_ok), .supply_ok(supply_ok),
      .events(events), .spi(spi), .intn_in(intn_in), .intn_out(intn_out), .intn_oe(intn_oe),
      .intn_pullup_en(intn_pullup_en), .pwm_checksum_strap_pin(strap),
      .reset_out_low(reset_out_low), .main_regulator_en(main_regulator_en),
      .wd_long_window(wd_long_window), .wd_running(wd_running), .checksum_en(checksum_en),
      .debug_mode(debug_mode));

   msc_host_model host (.hclk(hclk), .pull_down(pull_down), .intn_oe(intn_oe),
      .intn_out(intn_out), .intn_pullup_en(intn_pullup_en), .spi(spi), .intn_in(intn_in));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic chk1(input logic seen, input logic exp);
      check({31'h0, seen}, {31'h0, exp});
   endtask

   task automatic conclude();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // one single word transfer; reads leave a note for the monitor
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                      input logic [31:0] m);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      if (!w) notes.push_back('{v: d, m: m});
      do @(posedge hclk); while (!hreadyout);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= w ? d : ~d;
      do @(posedge hclk); while (!hreadyout);
   endtask

   task automatic cy(input int k);
      repeat (k) @(posedge hclk);
      #2;
   endtask

   task automatic ev(input msc_pkg::msc_event_t e);
      @(posedge hclk);
      events <= e;
      @(posedge hclk);
      events <= '0;
   endtask

   task automatic wait_rel();
      int k;
      k = 0;
      while (reset_out_low !== 1'b1 && k < 700) begin
         @(posedge hclk);
         k++;
      end
      #2;
      chk1(reset_out_low, 1'b1);
   endtask

   // status fields packed as the register shows them
   function automatic logic [31:0] st(input logic [2:0] md, input logic d, input logic ck,
                                      input logic rh, input logic f, input logic ip);
      return {23'h0, ip, f, 1'b0, rh, ck, d, md};
   endfunction

   // read data compared in its data phase, watchdog start on each release
   always @(posedge hclk) begin
      if (rd_dp && hreadyout) begin
         n = notes.pop_front();
         check(hrdata & n.m, n.v & n.m);
         chk1(hresp, 1'b0);
      end
      if (hresetn && reset_out_low && !prev_rst) chk1(wd_long_window, 1'b1);
      rd_dp <= hsel && htrans[1] && !hwrite && hresetn;
      prev_rst <= reset_out_low;
   end

   // clock
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   // watchdog on the whole run
   initial begin
      repeat (20000) @(posedge hclk);
      num_errors++;
      conclude();
   end

   // main sequence
   initial begin
      void'($urandom(86));
      {hresetn, hsel, hwrite, strap} = '0;
      {haddr, hwdata, htrans, events} = '0;
      hsize = 3'h2;
      {por_ok, supply_ok, pull_down} = 3'h7;
      num_errors = 0;
      check_count = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      cy(3);
      chk1(reset_out_low, 1'b0);
      host.command(32'h0, 1'b0);
      bus(32'h4, 1'b0, st(3'h0, 0, 0, 0, 0, 1), 32'h13f);
      wait_rel();
      chk1(intn_pullup_en, 1'b1);
      bus(32'h4, 1'b0, st(3'h0, 0, 1, 1, 1, 1), 32'h1bf);
      cy(60);
      bus(32'h4, 1'b0, 32'h0, 32'h88);
      host.command(32'h0, 1'b0);
      cy(2);
      chk1(debug_mode, 1'b1);
      bus(32'h0, 1'b1, 32'h9, 32'h0);
      bus(32'h4, 1'b0, 32'h9, 32'hf);
      ev(4'b0010);
      cy(2);
      chk1(intn_oe & !intn_out, 1'b1);
      chk1(reset_out_low & wd_running, 1'b1);
      cy(110);
      chk1(intn_oe, 1'b0);
      bus(32'h0, 1'b1, 32'ha, 32'h0);
      cy(1);
      chk1(main_regulator_en, 1'b1);
      bus(32'h4, 1'b0, 32'h2, 32'h7);
      bus(32'h0, 1'b1, 32'h9, 32'h0);
      bus(32'h0, 1'b1, 32'hb, 32'h0);
      cy(1);
      chk1(main_regulator_en, 1'b0);
      strap <= 1'b1;
      ev(4'b0001);
      cy(2);
      chk1(reset_out_low, 1'b0);
      bus(32'h4, 1'b0, 32'h4, 32'h7);
      wait_rel();
      bus(32'h4, 1'b0, 32'h29, 32'h3f);
      bus(32'h0, 1'b1, 32'h20, 32'h0);
      bus(32'h4, 1'b0, 32'h40, 32'h40);
      ev(4'b0010);
      cy(2);
      chk1(reset_out_low, 1'b0);
      wait_rel();
      fr[0] = ($urandom & 32'hfffffff0) | 32'h5;
      fr[1] = msc_pkg::CHECKSUM_ON_FRAME;
      fr[2] = msc_pkg::CHECKSUM_OFF_FRAME;
      ex = '{1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 3; i++) begin
         host.command(fr[i], 1'b1);
         cy(1);
         chk1(checksum_en, ex[i]);
      end
      strap <= 1'b0;
      ev(4'b1000);
      cy(2);
      chk1(reset_out_low, 1'b0);
      bus(32'h4, 1'b0, 32'h5, 32'h7);
      ev(4'b0001);
      wait_rel();
      bus(32'h4, 1'b0, 32'h39, 32'h3f);
      strap <= 1'b1;
      bus(32'h0, 1'b1, 32'h10, 32'h0);
      bus(32'h4, 1'b0, 32'h8, 32'h10f);
      wait_rel();
      bus(32'h4, 1'b0, 32'h18, 32'h11f);
      pull_down <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b0;
      cy(3);
      hresetn <= 1'b1;
      wait_rel();
      cy(60);
      host.command(32'h0, 1'b0);
      cy(2);
      chk1(debug_mode, 1'b0);
      pull_down <= 1'b1;
      cy(60);
      host.command(32'h0, 1'b0);
      cy(2);
      chk1(debug_mode, 1'b1);
      ev(4'b0100);
      cy(2);
      chk1(reset_out_low, 1'b0);
      chk1(debug_mode, 1'b0);
      wait_rel();
      host.command(32'h0, 1'b0);
      cy(2);
      chk1(debug_mode, 1'b0);
      bus(32'h40, 1'b1, $urandom, 32'h0);
      bus(32'h40, 1'b0, 32'h0, 32'hffffffff);
      conclude();
   end
endmodule
